/* File: src/output_list_pkg.sv */
// constants, command codes and carrier types for the output list sequencer
package output_list_pkg;
  localparam int TABLE_DEPTH    = 250;
  localparam int QUERY_MAX      = 250;
  localparam int READBACK_MAX   = 16;
  localparam int CLOCK_HZ       = 40_000_000;
  localparam int TICK_MS        = 10;
  localparam int TICK_CYCLES_DF = CLOCK_HZ / 1000 * TICK_MS;
  localparam int VALUE_W        = 16;
  localparam int PTR_W          = 8;
  localparam logic [15:0] DWELL_MIN   = 16'h0001;
  localparam logic [15:0] ERR_NONE    = 16'h0000;
  localparam logic [15:0] ERR_CMD     = 16'hff38;
  localparam logic [15:0] ERR_SETTING = 16'hff23;
  localparam logic [15:0] ERR_RANGE   = 16'hff22;
  localparam logic [15:0] RST_REPEAT  = 16'h0001;
  localparam logic [15:0] RST_SKIP    = 16'h0000;
  localparam logic        RST_DIR_UP  = 1'b1;
  localparam logic [15:0] RST_SETPT   = 16'h0000;
  localparam int          MODE_BIT    = 0;
  localparam int          DIR_BIT     = 0;

  typedef enum logic [4:0] {
    OP_CLEAR          = 5'h00,
    OP_RESET          = 5'h01,
    OP_START_SET      = 5'h02,
    OP_START_QUERY    = 5'h03,
    OP_VOLT_APPEND    = 5'h04,
    OP_VOLT_READBACK  = 5'h05,
    OP_VOLT_POINTER   = 5'h06,
    OP_DWELL_APPEND   = 5'h07,
    OP_DWELL_READBACK = 5'h08,
    OP_DWELL_POINTER  = 5'h09,
    OP_REPEAT_COUNT   = 5'h0a,
    OP_FIRST_SKIP     = 5'h0b,
    OP_DIRECTION      = 5'h0c,
    OP_RUN_SELECT     = 5'h0d,
    OP_SETPOINT_SET   = 5'h0e,
    OP_SETPOINT_QUERY = 5'h0f,
    OP_SENSED_CURRENT = 5'h10,
    OP_SENSED_VOLTAGE = 5'h11
  } op_t;

  typedef struct packed {
    logic         valid;
    op_t          op;
    logic [15:0]  arg;
  } cmd_t;

  typedef struct packed {
    logic         valid;
    logic         last;
    logic [15:0]  err;
    logic [15:0]  data;
  } rsp_t;
endpackage

/* File: src/output_list_sequencer.sv */
// output list sequencer: tables, readback, stepping engine
`timescale 1ns/10ps
module output_list_sequencer
  import output_list_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DF,
  parameter int DEPTH       = TABLE_DEPTH
)(
  input  wire logic                clock,
  input  wire logic                nrst,
  input  wire logic                enable,
  input  wire cmd_t                cmd,
  input  wire logic [VALUE_W-1:0]  sensed_voltage,
  input  wire logic [VALUE_W-1:0]  sensed_current,
  output rsp_t                     rsp,
  output logic [VALUE_W-1:0]       setpoint,
  output logic                     running
);
  localparam int PW = $clog2(TICK_CYCLES + 1);

  generate
    if (DEPTH < 2 || DEPTH > 255 || TICK_CYCLES < 2)
    begin : g_bad
      $error("output_list_sequencer: unsupported parameters");
    end
  endgenerate

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_VOLT  = 2'b01,
    ST_DWELL = 2'b10
  } rb_state_t;

  logic [VALUE_W-1:0] vt [DEPTH];
  logic [VALUE_W-1:0] dt [DEPTH];
  logic [PTR_W-1:0]   vcount;
  logic [PTR_W-1:0]   dcount;
  logic [PTR_W-1:0]   qstart;
  logic [15:0]        repeat_cnt;
  logic [15:0]        skip_cnt;
  logic               dir_up;
  rb_state_t          state;
  logic [PTR_W-1:0]   rb_loc;
  logic [3:0]         rb_seen;
  logic [PTR_W-1:0]   idx;
  logic [15:0]        pass_left;
  logic [15:0]        dwell_left;
  logic [PW-1:0]      prescale;
  logic [VALUE_W-1:0] saved_setpoint;

  logic               accept;
  logic               table_op;
  logic               busy_reject;
  logic               unbalanced;
  logic               start_req;
  logic               stop_req;
  logic               clear_req;
  logic [PTR_W-1:0]   qloc;
  logic [PTR_W-1:0]   last_loc;
  logic [PTR_W-1:0]   skip_first;
  logic               tick;
  logic               step_done;
  logic               end_of_pass;
  logic               finish;
  logic               load;
  logic [PTR_W-1:0]   load_idx;
  logic [PTR_W-1:0]   rb_count;
  logic [VALUE_W-1:0] rb_value;

  assign accept = enable && cmd.valid && state == ST_IDLE;
  assign table_op = cmd.op inside {OP_CLEAR, OP_START_SET, OP_VOLT_APPEND,
                                   OP_DWELL_APPEND, OP_REPEAT_COUNT,
                                   OP_FIRST_SKIP, OP_DIRECTION};
  assign busy_reject = running && table_op;
  assign unbalanced = (dcount > 8'h01 && dcount != vcount)
                      || vcount == 8'h00 || dcount == 8'h00;
  assign start_req = accept && cmd.op == OP_RUN_SELECT
                     && cmd.arg[MODE_BIT] && !running && !unbalanced;
  assign stop_req  = accept && cmd.op == OP_RUN_SELECT
                     && !cmd.arg[MODE_BIT] && running;
  assign clear_req = accept && !busy_reject
                     && (cmd.op == OP_CLEAR || cmd.op == OP_RESET);
  assign qloc = (qstart == 8'h00) ? 8'h00 : 8'(qstart - 8'h01);
  assign last_loc = 8'(vcount - 8'h01);
  // an oversized skip is held to the last step so a pass never empties
  assign skip_first = (skip_cnt >= {8'h00, vcount}) ? last_loc
                                                    : skip_cnt[PTR_W-1:0];
  assign tick = prescale == PW'(TICK_CYCLES - 1);
  assign step_done = running && tick && dwell_left == 16'h0001;
  assign end_of_pass = dir_up ? (idx == last_loc) : (idx == 8'h00);
  assign finish = step_done && end_of_pass && repeat_cnt != 16'h0000
                  && pass_left == 16'h0001;
  assign load = start_req || (step_done && !finish);

  always_comb
  begin
    if (start_req)
      load_idx = dir_up ? 8'h00 : last_loc;
    else if (!end_of_pass)
      load_idx = dir_up ? 8'(idx + 8'h01) : 8'(idx - 8'h01);
    else
      load_idx = dir_up ? skip_first : last_loc;
  end

  assign rb_count = (state == ST_VOLT) ? vcount : dcount;
  assign rb_value = (state == ST_VOLT) ? vt[rb_loc] : dt[rb_loc];

  // table storage; memories carry no reset, the pointers define contents
  always_ff @(posedge clock)
  begin
    if (enable && accept && !busy_reject)
    begin
      if (cmd.op == OP_VOLT_APPEND && vcount < 8'(DEPTH))
        vt[vcount] <= cmd.arg;
      if (cmd.op == OP_DWELL_APPEND && dcount < 8'(DEPTH)
          && cmd.arg >= DWELL_MIN)
        dt[dcount] <= cmd.arg;
    end
  end

  // pointers and list settings
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      vcount     <= 8'h00;
      dcount     <= 8'h00;
      qstart     <= 8'h00;
      repeat_cnt <= RST_REPEAT;
      skip_cnt   <= RST_SKIP;
      dir_up     <= RST_DIR_UP;
    end
    else if (enable)
    begin
      if (clear_req)
      begin
        vcount     <= 8'h00;
        dcount     <= 8'h00;
        qstart     <= 8'h00;
        repeat_cnt <= RST_REPEAT;
        skip_cnt   <= RST_SKIP;
        dir_up     <= RST_DIR_UP;
      end
      else if (accept && !busy_reject)
      begin
        case (cmd.op)
          OP_VOLT_APPEND:
            if (vcount < 8'(DEPTH))
              vcount <= 8'(vcount + 8'h01);
          OP_DWELL_APPEND:
            if (dcount < 8'(DEPTH) && cmd.arg >= DWELL_MIN)
              dcount <= 8'(dcount + 8'h01);
          OP_START_SET:
            if (cmd.arg <= 16'(QUERY_MAX))
              qstart <= cmd.arg[PTR_W-1:0];
          OP_REPEAT_COUNT: repeat_cnt <= cmd.arg;
          OP_FIRST_SKIP:   skip_cnt <= cmd.arg;
          OP_DIRECTION:    dir_up <= cmd.arg[DIR_BIT];
          default:         ;
        endcase
      end
    end
  end

  // stepping engine
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      running        <= 1'b0;
      idx            <= 8'h00;
      pass_left      <= 16'h0000;
      dwell_left     <= 16'h0000;
      prescale       <= '0;
      setpoint       <= RST_SETPT;
      saved_setpoint <= RST_SETPT;
    end
    else if (enable)
    begin
      if (stop_req || (accept && cmd.op == OP_RESET))
      begin
        running  <= 1'b0;
        setpoint <= saved_setpoint;
      end
      else if (accept && cmd.op == OP_SETPOINT_SET && !running)
        setpoint <= cmd.arg;
      else if (finish)
        running <= 1'b0;
      else if (load)
      begin
        running    <= 1'b1;
        idx        <= load_idx;
        prescale   <= '0;
        // single-entry tables feed location 0 to every step
        setpoint   <= (vcount == 8'h01) ? vt[0] : vt[load_idx];
        dwell_left <= (dcount == 8'h01) ? dt[0] : dt[load_idx];
        if (start_req)
        begin
          saved_setpoint <= setpoint;
          pass_left      <= repeat_cnt;
        end
        else if (end_of_pass && repeat_cnt != 16'h0000)
          pass_left <= 16'(pass_left - 16'h0001);
      end
      else if (running)
      begin
        prescale <= tick ? '0 : PW'(prescale + 1'b1);
        if (tick)
          dwell_left <= 16'(dwell_left - 16'h0001);
      end
    end
  end

  // command answers and readback streaming
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      state   <= ST_IDLE;
      rb_loc  <= 8'h00;
      rb_seen <= 4'h0;
      rsp     <= '0;
    end
    else if (enable)
    begin
      rsp <= '0;
      if (state != ST_IDLE)
      begin
        rsp.valid <= 1'b1;
        rsp.err   <= ERR_NONE;
        if (rb_loc >= rb_count)
        begin
          rsp.last <= 1'b1;
          state    <= ST_IDLE;
        end
        else
        begin
          rsp.data <= rb_value;
          rb_loc   <= 8'(rb_loc + 8'h01);
          rb_seen  <= 4'(rb_seen + 4'h1);
          if (rb_seen == 4'(READBACK_MAX - 1)
              || 8'(rb_loc + 8'h01) >= rb_count)
          begin
            rsp.last <= 1'b1;
            state    <= ST_IDLE;
          end
        end
      end
      else if (accept)
      begin
        rsp.valid <= 1'b1;
        rsp.last  <= 1'b1;
        rsp.err   <= ERR_NONE;
        if (busy_reject)
          rsp.err <= ERR_CMD;
        else
        begin
          case (cmd.op)
            OP_START_QUERY:    rsp.data <= {8'h00, qstart};
            OP_VOLT_POINTER:   rsp.data <= {8'h00, vcount};
            OP_DWELL_POINTER:  rsp.data <= {8'h00, dcount};
            OP_SETPOINT_QUERY: rsp.data <= setpoint;
            OP_SENSED_CURRENT: rsp.data <= sensed_current;
            OP_SENSED_VOLTAGE: rsp.data <= sensed_voltage;
            OP_START_SET:
              if (cmd.arg > 16'(QUERY_MAX))
                rsp.err <= ERR_RANGE;
            OP_VOLT_APPEND:
              if (vcount >= 8'(DEPTH))
                rsp.err <= ERR_RANGE;
            OP_DWELL_APPEND:
              if (dcount >= 8'(DEPTH) || cmd.arg < DWELL_MIN)
                rsp.err <= ERR_RANGE;
            OP_SETPOINT_SET:
              if (running)
                rsp.err <= ERR_CMD;
            OP_RUN_SELECT:
              if (cmd.arg[MODE_BIT] && !running && unbalanced)
                rsp.err <= ERR_SETTING;
            OP_VOLT_READBACK, OP_DWELL_READBACK:
            begin
              rsp     <= '0;
              state   <= (cmd.op == OP_VOLT_READBACK) ? ST_VOLT : ST_DWELL;
              rb_loc  <= qloc;
              rb_seen <= 4'h0;
            end
            default: ;
          endcase
        end
      end
    end
  end

  default clocking cb @(posedge clock iff enable);
  endclocking
  default disable iff (!nrst);

  sequence s_run_request;
    accept && cmd.op == OP_RUN_SELECT && cmd.arg[MODE_BIT] && !running;
  endsequence
  sequence s_refused;
    !running && rsp.valid && rsp.err == ERR_SETTING;
  endsequence

  a_clear_pointers: assert property (clear_req |=>
    vcount == 8'h00 && dcount == 8'h00 && qstart == 8'h00)
    else $error("clear left a pointer set");
  a_append_count: assert property (accept && !running
    && cmd.op == OP_VOLT_APPEND && vcount < 8'(DEPTH)
    |=> vcount == 8'($past(vcount) + 8'h01))
    else $error("voltage append did not advance pointer");
  a_table_cap: assert property (vcount <= 8'(DEPTH))
    else $error("voltage table beyond capacity");
  a_busy_reject: assert property (accept && busy_reject
    |=> rsp.valid && rsp.err == ERR_CMD && $stable(vcount))
    else $error("table command accepted while running");
  a_fixed_stop: assert property (stop_req |=> !running)
    else $error("fixed mode did not stop the list");
  a_unbal_refuse: assert property (s_run_request ##0 unbalanced
    |=> s_refused)
    else $error("unbalanced tables were started");
  a_start_query: assert property (accept && cmd.op == OP_START_QUERY
    |=> rsp.valid && rsp.data == {8'h00, $past(qstart)})
    else $error("query start readback wrong");
  a_step_hold: assert property (running && !load && !stop_req
    |=> $stable(setpoint) || !running)
    else $error("setpoint moved inside a dwell");
  a_finish_hold: assert property (finish
    |=> !running && $stable(setpoint))
    else $error("completion changed the setpoint");
  a_down_start: assert property (start_req && !dir_up
    |=> running && idx == 8'($past(vcount) - 8'h01))
    else $error("down run did not begin at last location");
  a_skip_wrap: assert property (step_done && end_of_pass && dir_up
    && !finish |=> idx == $past(skip_first))
    else $error("later pass did not skip leading steps");
  a_readback_len: assert property (state != ST_IDLE
    && rb_seen == 4'(READBACK_MAX - 1) && rb_loc < rb_count
    |=> state == ST_IDLE && rsp.last)
    else $error("readback ran past sixteen values");
endmodule // output_list_sequencer

/* File: tb/list_host.sv */
// host model: issues one command at a time and gathers the answer beats
`timescale 1ns/10ps
module list_host
  import output_list_pkg::*;
(
  input  wire logic   clock,
  input  wire rsp_t   rsp,
  output cmd_t        cmd,
  output logic [15:0] sensed_voltage,
  output logic [15:0] sensed_current
);
  logic [15:0] beats[$];
  logic [15:0] err;

  initial
  begin
    cmd = '0;
    sensed_voltage = 16'h1234;
    sensed_current = 16'h0567;
  end

  // one table value per command: long loads are split by the caller
  task automatic xfer(input op_t op, input logic [15:0] arg);
    int n;
    beats = {};
    err = 16'h0000;
    @(posedge clock);
    #1;
    cmd = {1'b1, op, arg};
    @(posedge clock);
    #1;
    cmd.valid = 1'b0;
    n = 0;
    // no new command until the last beat: readback would drop it
    while (n < 40)
    begin
      if (rsp.valid === 1'b1)
      begin
        beats.push_back(rsp.data);
        if (rsp.err !== 16'h0000)
          err = rsp.err;
        if (rsp.last === 1'b1)
          n = 40;
      end
      if (n < 40)
      begin
        n++;
        @(posedge clock);
        #1;
      end
    end
  endtask
endmodule // list_host

/* File: tb/output_list_sequencer_tb.sv */
// self-checking bench for the output list sequencer
`timescale 1ns/10ps
module output_list_sequencer_tb;
  import output_list_pkg::*;
  localparam int TICKS = 4;
  logic        clock;
  logic        nrst;
  logic        enable;
  cmd_t        cmd;
  rsp_t        rsp;
  logic [15:0] sensed_voltage;
  logic [15:0] sensed_current;
  logic [15:0] setpoint;
  logic        running;
  logic [15:0] seq[$];
  int          cycles;
  int          n_errors = 0;
  int          check_count = 0;

  output_list_sequencer #(.TICK_CYCLES(TICKS)) i_dut (
    .clock(clock), .nrst(nrst), .enable(enable), .cmd(cmd),
    .sensed_voltage(sensed_voltage), .sensed_current(sensed_current),
    .rsp(rsp), .setpoint(setpoint), .running(running));

  list_host i_host (
    .clock(clock), .rsp(rsp), .cmd(cmd),
    .sensed_voltage(sensed_voltage), .sensed_current(sensed_current));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic do_cmd(input op_t op, input logic [15:0] arg,
                        input logic [15:0] exp_err);
    i_host.xfer(op, arg);
    chk(16'(i_host.beats.size()), 16'h0001);
    chk(i_host.err, exp_err);
  endtask

  task automatic ask(input op_t op, input logic [15:0] exp);
    do_cmd(op, 16'h0000, ERR_NONE);
    chk(i_host.beats[0], exp);
  endtask

  task automatic load(input op_t op, input int n, input int base);
    for (int i = 0; i < n; i++)
      do_cmd(op, 16'(base + i), ERR_NONE);
  endtask

  // records each new setpoint while the list runs
  task automatic run_list();
    do_cmd(OP_RUN_SELECT, 16'h0001, ERR_NONE);
    seq = {};
    cycles = 0;
    while (running === 1'b1 && cycles < 3000)
    begin
      if (seq.size() == 0 || seq[$] !== setpoint)
        seq.push_back(setpoint);
      cycles++;
      @(posedge clock);
      #1;
    end
    chk(16'(running), 16'h0000);
  endtask

  // expected order of the 5,6,7 table for a pass count, skip and direction
  task automatic chk_run(input int rep, input int skip, input logic up);
    int k;
    k = 0;
    for (int p = 0; p < rep; p++)
      for (int s = 0; s < 3; s++)
        if (!up || p == 0 || s >= skip)
        begin
          chk(seq[k], up ? 16'(5 + s) : 16'(7 - s));
          k++;
        end
    chk(16'(seq.size()), 16'(k));
  endtask

  task automatic t_defaults();
    ask(OP_VOLT_POINTER, 16'h0000);
    ask(OP_DWELL_POINTER, 16'h0000);
    ask(OP_START_QUERY, 16'h0000);
  endtask

  task automatic t_tables();
    load(OP_VOLT_APPEND, 20, 16'h0100);
    ask(OP_VOLT_POINTER, 16'd20);
    i_host.xfer(OP_VOLT_READBACK, 16'h0000);
    chk(16'(i_host.beats.size()), 16'd16);
    for (int i = 0; i < 16; i++)
      chk(i_host.beats[i], 16'(16'h0100 + i));
    do_cmd(OP_START_SET, 16'd3, ERR_NONE);
    ask(OP_START_QUERY, 16'd3);
    i_host.xfer(OP_VOLT_READBACK, 16'h0000);
    chk(i_host.beats[0], 16'h0102);
    chk(16'(i_host.beats.size()), 16'd16);
    do_cmd(OP_START_SET, 16'd250, ERR_NONE);
    do_cmd(OP_START_SET, 16'd251, ERR_RANGE);
    ask(OP_START_QUERY, 16'd250);
    load(OP_VOLT_APPEND, 230, 16'h0200);
    ask(OP_VOLT_POINTER, 16'd250);
    do_cmd(OP_VOLT_APPEND, 16'h0001, ERR_RANGE);
    do_cmd(OP_CLEAR, 16'h0000, ERR_NONE);
    ask(OP_VOLT_POINTER, 16'h0000);
    ask(OP_START_QUERY, 16'h0000);
  endtask

  task automatic t_run();
    load(OP_VOLT_APPEND, 3, 5);
    do_cmd(OP_DWELL_APPEND, 16'h0000, ERR_RANGE);
    do_cmd(OP_DWELL_APPEND, 16'h0002, ERR_NONE);
    ask(OP_DWELL_POINTER, 16'h0001);
    run_list();
    chk_run(1, 0, 1'b1);
    // one step lasts dwell * tick; allow one cycle of sampling slack
    chk(16'(cycles >= 23 && cycles <= 25), 16'h0001);
    ask(OP_SETPOINT_QUERY, 16'h0007);
    chk(setpoint, 16'h0007);
  endtask

  task automatic t_order();
    do_cmd(OP_REPEAT_COUNT, 16'h0002, ERR_NONE);
    do_cmd(OP_FIRST_SKIP, 16'h0001, ERR_NONE);
    run_list();
    chk_run(2, 1, 1'b1);
    do_cmd(OP_DIRECTION, 16'h0000, ERR_NONE);
    run_list();
    chk_run(2, 1, 1'b0);
  endtask

  task automatic t_stop();
    logic [15:0] held;
    do_cmd(OP_SETPOINT_SET, 16'h0042, ERR_NONE);
    do_cmd(OP_REPEAT_COUNT, 16'h0000, ERR_NONE);
    do_cmd(OP_DIRECTION, 16'h0001, ERR_NONE);
    do_cmd(OP_RUN_SELECT, 16'h0001, ERR_NONE);
    repeat (200) @(posedge clock);
    #1;
    chk(16'(running), 16'h0001);
    // a low enable must freeze the stepping engine mid-dwell
    enable = 1'b0;
    held = setpoint;
    repeat (20) @(posedge clock);
    #1;
    chk(setpoint, held);
    chk(16'(running), 16'h0001);
    enable = 1'b1;
    do_cmd(OP_SETPOINT_SET, 16'h0001, ERR_CMD);
    do_cmd(OP_VOLT_APPEND, 16'h0009, ERR_CMD);
    do_cmd(OP_DWELL_APPEND, 16'h0001, ERR_CMD);
    do_cmd(OP_CLEAR, 16'h0000, ERR_CMD);
    ask(OP_VOLT_POINTER, 16'h0003);
    do_cmd(OP_RUN_SELECT, 16'h0000, ERR_NONE);
    chk(16'(running), 16'h0000);
    chk(setpoint, 16'h0042);
  endtask

  task automatic t_refuse();
    do_cmd(OP_CLEAR, 16'h0000, ERR_NONE);
    load(OP_VOLT_APPEND, 3, 5);
    load(OP_DWELL_APPEND, 2, 1);
    i_host.xfer(OP_DWELL_READBACK, 16'h0000);
    chk(16'(i_host.beats.size()), 16'h0002);
    chk(i_host.beats[1], 16'h0002);
    do_cmd(OP_RUN_SELECT, 16'h0001, ERR_SETTING);
    chk(16'(running), 16'h0000);
    do_cmd(OP_CLEAR, 16'h0000, ERR_NONE);
    load(OP_VOLT_APPEND, 1, 9);
    load(OP_DWELL_APPEND, 1, 1);
    run_list();
    chk(seq[0], 16'h0009);
    chk(setpoint, 16'h0009);
    ask(OP_SENSED_VOLTAGE, 16'h1234);
    ask(OP_SENSED_CURRENT, 16'h0567);
    do_cmd(OP_RESET, 16'h0000, ERR_NONE);
    ask(OP_VOLT_POINTER, 16'h0000);
  endtask

  initial
  begin
    nrst = 1'b0;
    enable = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    nrst = 1'b1;
    t_defaults();
    t_tables();
    t_run();
    t_order();
    t_stop();
    t_refuse();
    tally_and_finish();
  end

  // the whole sequence needs well under 5000 cycles
  initial
  begin
    #(25 * 20000);
    n_errors++;
    tally_and_finish();
  end
endmodule // output_list_sequencer_tb
